// [single_wire_bus_master.sv]
/*
  Single-wire bus master: reset/presence, write-zero, write-one and read slots,
  started by self-clearing control bits over a plain register port.
  Assumes an external pull-up on the bus line and a slave on the far side.
*/
// Behaviour
// - Each exchange starts with a reset pulse of at least 480 us, then presence.
// - Reset request bit starts reset; hardware clears it after presence sampling.
// - Presence flag latches the inverted sampled bus: 1 slave found, 0 none.
// - Write-zero slot lasts 117 us with the bus low for 100 us.
// - Write-zero bit starts the slot and clears itself when it completes.
// - Write-one and read slots share timing: short low, then release.
// - Write-one/read bit starts the slot and clears itself when done.
// - At write-one/read slot end the read result bit takes the sampled bus value.
// - Recovery after reset pulse is 512 us nominal, at least 480.
// - Write-zero low time is 100 us nominal, within 60 to 120.
// - Write-one/read low time is 5 us nominal, within 1 to 15.
// - Read data sampled 13 us after the falling edge, never past 15.
// - Slot timing relative error stays within 0.0645.
// - Microsecond tick comes from the main clock by an integer divider.
// - With an integer MHz clock the tick is exactly 1 MHz.
// - Main clock should not be below 10 MHz.
`timescale 1ns/10ps
module single_wire_bus_master #(
  parameter int DIV_DEFAULT = swb_pkg::DIV_RATIO // Clocks per microsecond tick
) (
  input wire logic clk, // Main clock, 10 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic [1:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic bus_i, // Bus line level
  output logic bus_o, // Bus drive value, always low
  output logic bus_oe, // High while pulling the bus low
  output logic busy // Sequence in progress
);

  // ----------------------------------------
  // Microsecond tick
  // ----------------------------------------
  logic [swb_pkg::DIV_W-1:0] div_q;
  logic tick;

  // Ratio is software-visible so non-integer clocks can pick the nearest divide
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      div_q <= swb_pkg::DIV_W'(DIV_DEFAULT);
    else if (wr && addr == swb_pkg::ADDR_DIV)
      div_q <= wdata;
  end

  tick_divider #(.W(swb_pkg::DIV_W)) u_div (
    .clk(clk),
    .resetn(resetn),
    .ratio(div_q),
    .tick(tick)
  );

  // ----------------------------------------
  // Bus input synchroniser
  // ----------------------------------------
  logic sync1_q;
  logic sync2_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= bus_i;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  swb_pkg::seq_state_t state_q;
  logic [swb_pkg::US_W-1:0] us_q;
  logic reset_req_q;
  logic wr0_req_q;
  logic wr1rd_req_q;
  logic presence_q;
  logic rdres_q;
  logic sample_q;
  logic drive_low_q;
  logic ctrl_wr;
  logic seq_done;

  assign ctrl_wr = wr && addr == swb_pkg::ADDR_CTRL;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= swb_pkg::ST_IDLE;
      us_q <= '0;
    end
    else
    begin
      case (state_q)
        swb_pkg::ST_IDLE:
        begin
          us_q <= '0;
          // Start on a tick so every phase is whole ticks long, no partial first us
          if (tick)
          begin
            // Reset takes priority: it must precede any slot
            if (reset_req_q)
              state_q <= swb_pkg::ST_RESET_LOW;
            else if (wr0_req_q)
              state_q <= swb_pkg::ST_ZERO_SLOT;
            else if (wr1rd_req_q)
              state_q <= swb_pkg::ST_ONE_SLOT;
          end
        end
        swb_pkg::ST_RESET_LOW:
          if (tick)
          begin
            if (us_q == swb_pkg::US_W'(swb_pkg::RESET_LOW_US - 1))
            begin
              us_q <= '0;
              state_q <= swb_pkg::ST_RESET_RECOV;
            end
            else
              us_q <= us_q + swb_pkg::US_W'(1);
          end
        swb_pkg::ST_RESET_RECOV:
          if (tick)
          begin
            if (us_q == swb_pkg::US_W'(swb_pkg::RESET_RECOVERY_US - 1))
              state_q <= swb_pkg::ST_IDLE;
            else
              us_q <= us_q + swb_pkg::US_W'(1);
          end
        swb_pkg::ST_ZERO_SLOT, swb_pkg::ST_ONE_SLOT:
          if (tick)
          begin
            if (us_q == swb_pkg::US_W'(swb_pkg::SLOT_TOTAL_US - 1))
              state_q <= swb_pkg::ST_IDLE;
            else
              us_q <= us_q + swb_pkg::US_W'(1);
          end
        default:
          state_q <= swb_pkg::ST_IDLE;
      endcase
    end
  end

  assign seq_done = tick && ((state_q == swb_pkg::ST_RESET_RECOV
    && us_q == swb_pkg::US_W'(swb_pkg::RESET_RECOVERY_US - 1))
    || ((state_q == swb_pkg::ST_ZERO_SLOT || state_q == swb_pkg::ST_ONE_SLOT)
    && us_q == swb_pkg::US_W'(swb_pkg::SLOT_TOTAL_US - 1)));

  // ----------------------------------------
  // Bus drive, open drain
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      drive_low_q <= 1'b0;
    else
    begin
      case (state_q)
        swb_pkg::ST_RESET_LOW:
          drive_low_q <= 1'b1;
        swb_pkg::ST_ZERO_SLOT:
          drive_low_q <= us_q < swb_pkg::US_W'(swb_pkg::ZERO_SLOT_LOW_US);
        swb_pkg::ST_ONE_SLOT:
          drive_low_q <= us_q < swb_pkg::US_W'(swb_pkg::READ_SLOT_LOW_US);
        default:
          drive_low_q <= 1'b0;
      endcase
    end
  end

  assign bus_o = 1'b0;
  assign bus_oe = drive_low_q;
  // A pending request counts as busy while it waits for the next tick
  assign busy = state_q != swb_pkg::ST_IDLE || reset_req_q || wr0_req_q || wr1rd_req_q;

  // ----------------------------------------
  // Sampling of presence and read data
  // ----------------------------------------
  // Slave overrides the released high to signal zero, so sample the line level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sample_q <= 1'b1;
    else if (tick && state_q == swb_pkg::ST_ONE_SLOT
             && us_q == swb_pkg::US_W'(swb_pkg::READ_SAMPLE_US - 1))
      sample_q <= sync2_q;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      presence_q <= 1'b0;
    else if (tick && state_q == swb_pkg::ST_RESET_RECOV
             && us_q == swb_pkg::US_W'(swb_pkg::PRESENCE_SAMPLE_US - 1))
      presence_q <= !sync2_q;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdres_q <= 1'b0;
    else if (seq_done && state_q == swb_pkg::ST_ONE_SLOT)
      rdres_q <= sample_q;
  end

  // ----------------------------------------
  // Self-clearing control bits
  // ----------------------------------------
  // A software set in the completion cycle wins, so the request is not lost
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reset_req_q <= 1'b0;
    else if (ctrl_wr && wdata[swb_pkg::CTRL_RESET_BIT])
      reset_req_q <= 1'b1;
    else if (seq_done && state_q == swb_pkg::ST_RESET_RECOV)
      reset_req_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wr0_req_q <= 1'b0;
    else if (ctrl_wr && wdata[swb_pkg::CTRL_WR0_BIT])
      wr0_req_q <= 1'b1;
    else if (seq_done && state_q == swb_pkg::ST_ZERO_SLOT)
      wr0_req_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wr1rd_req_q <= 1'b0;
    else if (ctrl_wr && wdata[swb_pkg::CTRL_WR1RD_BIT])
      wr1rd_req_q <= 1'b1;
    else if (seq_done && state_q == swb_pkg::ST_ONE_SLOT)
      wr1rd_req_q <= 1'b0;
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (rd)
    begin
      rdata <= 8'h00;
      if (addr == swb_pkg::ADDR_CTRL)
      begin
        rdata[swb_pkg::CTRL_RESET_BIT] <= reset_req_q;
        rdata[swb_pkg::CTRL_PRES_BIT] <= presence_q;
        rdata[swb_pkg::CTRL_WR0_BIT] <= wr0_req_q;
        rdata[swb_pkg::CTRL_WR1RD_BIT] <= wr1rd_req_q;
        rdata[swb_pkg::CTRL_RDRES_BIT] <= rdres_q;
        rdata[swb_pkg::CTRL_BUSY_BIT] <= busy;
      end
      else if (addr == swb_pkg::ADDR_DIV)
        rdata <= div_q;
    end
    else
      rdata <= 8'h00;
  end

endmodule : single_wire_bus_master

// [swb_pkg.sv]
/*
  Package for the single-wire bus master: timing figures in microseconds,
  tick divider ratio, and the state type of the slot sequencer.
  Assumes a 10 MHz main clock; all timing is counted in 1 us ticks.
*/
package swb_pkg;

  // ----------------------------------------
  // Clock and tick
  // ----------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int TICK_KHZ = 1000;
  localparam int DIV_RATIO = CLK_KHZ / TICK_KHZ;
  localparam int DIV_W = 8;

  // ----------------------------------------
  // Bus timing, microseconds
  // ----------------------------------------
  localparam int RESET_LOW_US = 511;
  localparam int RESET_RECOVERY_US = 512;
  localparam int PRESENCE_SAMPLE_US = 68;
  localparam int ZERO_SLOT_LOW_US = 100;
  localparam int SLOT_TOTAL_US = 117;
  localparam int READ_SLOT_LOW_US = 5;
  localparam int READ_SAMPLE_US = 13;
  localparam int US_W = 10;

  // ----------------------------------------
  // Register map (plain port, word index)
  // ----------------------------------------
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DIV = 2'h1;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_PRES_BIT = 1;
  localparam int CTRL_WR0_BIT = 2;
  localparam int CTRL_WR1RD_BIT = 3;
  localparam int CTRL_RDRES_BIT = 4;
  localparam int CTRL_BUSY_BIT = 5;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET_LOW,
    ST_RESET_RECOV,
    ST_ZERO_SLOT,
    ST_ONE_SLOT
  } seq_state_t;

endpackage : swb_pkg

// [tick_divider.sv]
/*
  Integer clock divider giving a one-cycle tick enable.
  Assumes ratio is held steady while counting; a change does not restart the count.
*/
`timescale 1ns/10ps
module tick_divider #(
  parameter int W = 8
) (
  input wire logic clk, // Main clock
  input wire logic resetn, // Async reset, active low
  input wire logic [W-1:0] ratio, // Clocks per tick, 0 and 1 give every cycle
  output logic tick // One-cycle enable
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= '0;
    else if (cnt_q + W'(1) >= ratio)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + W'(1);
  end

  assign tick = (cnt_q + W'(1) >= ratio);
endmodule : tick_divider

// [swb_assertions.sv]
/* Port checker for the single-wire bus master.
   Assumes the divider stays at its reset value of 10 clocks per microsecond. */
`timescale 1ns/10ps
module swb_assertions (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic [1:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic bus_o, // Drive value
  input wire logic bus_oe, // Drive enable
  input wire logic busy // Sequence running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Pulse length counters
  // ----
  int oe_len_q;
  int busy_len_q;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) oe_len_q <= 0;
    else oe_len_q <= bus_oe ? oe_len_q + 1 : 0;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) busy_len_q <= 0;
    else busy_len_q <= busy ? busy_len_q + 1 : 0;
  sequence start_req;
    wr && addr == swb_pkg::ADDR_CTRL && (wdata & 8'h0D) != 8'h00 && !busy;
  endsequence
  // ----
  // Checks
  // ----
  start_busy_a: assert property (start_req |=> busy)
    else $error("busy did not follow a start write");
  drive_soon_a: assert property (start_req ##1 busy |-> ##[0:24] bus_oe)
    else $error("bus not pulled low after start");
  oe_idle_a: assert property (!busy |-> !bus_oe)
    else $error("bus pulled low while idle");
  bus_low_a: assert property (bus_o == 1'b0)
    else $error("bus drive value not low");
  // Low lengths are whole ticks, so one tick off lands outside every low window; busy windows span 18 cycles, wider than a tick
  low_len_a: assert property ($fell(bus_oe) |->
    oe_len_q inside {[47:53], [997:1003], [5107:5113]})
    else $error("low pulse length wrong");
  busy_len_a: assert property ($fell(busy) |->
    busy_len_q inside {[1168:1186], [10228:10246]})
    else $error("sequence length wrong");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  busy_field_a: assert property (rd && addr == swb_pkg::ADDR_CTRL |=>
    rdata[swb_pkg::CTRL_BUSY_BIT] == $past(busy))
    else $error("busy field wrong");
endmodule : swb_assertions
bind single_wire_bus_master swb_assertions swb_assertions_inst (.clk(clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus_o(bus_o),
  .bus_oe(bus_oe), .busy(busy));

// [swb_slave_model.sv]
/* Behavioural slave on the single-wire bus.
   Assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/10ps
module swb_slave_model (
  input wire logic line, // Resolved bus level
  input wire logic present, // Slave attached
  input wire logic ret_bit, // Bit returned in read slots
  input wire logic [7:0] wait_us, // Presence delay
  input wire logic [7:0] pulse_us, // Presence length
  output logic pull // High while pulling low
);
  time fall_t;
  initial pull = 1'b0;
  initial fall_t = 0;
  always @(negedge line)
    if (!pull)
    begin
      fall_t = $time;
      if (present && !ret_bit)
      begin
        pull = 1'b1;
        #30000;
        pull = 1'b0;
      end
    end
  // Only a low of 480 us or more counts as a reset pulse
  always @(posedge line)
    if (present && !pull && $time - fall_t >= 480000)
    begin
      #(wait_us * 1000);
      pull = 1'b1;
      #(pulse_us * 1000);
      fall_t = $time;
      pull = 1'b0;
    end
endmodule : swb_slave_model

// [testbench.sv]
/* Self-checking bench for the single-wire bus master with a slave model.
   Assumes the divider stays at its reset value. */
`timescale 1ns/10ps
module testbench;
  logic clk, resetn, wr, rd, present, ret_bit, pull, bus_o, bus_oe, busy, pres, rres;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, wait_us, pulse_us, got;
  wire line = !(bus_oe || pull);
  int bad_count, n_compared;
  single_wire_bus_master single_wire_bus_master_inst (.clk(clk), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus_i(line),
    .bus_o(bus_o), .bus_oe(bus_oe), .busy(busy));
  swb_slave_model swb_slave_model_inst (.line(line), .present(present), .ret_bit(ret_bit),
    .wait_us(wait_us), .pulse_us(pulse_us), .pull(pull));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----
  // Bus tasks and checks
  // ----
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : put
  task automatic get(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : get
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] ctrl_exp(input logic [7:0] s, input logic p, input logic r);
    return s | {2'b00, s != 8'h00, r, 2'b00, p, 1'b0};
  endfunction : ctrl_exp
  task automatic idle;
    for (int n = 0; n < 12000 && busy !== 1'b0; n++) @(posedge clk) #1;
  endtask : idle
  task automatic do_reset(input logic here);
    present = here;
    wait_us = 8'h0F + 8'($urandom % 46);
    pulse_us = 8'h3C + 8'($urandom % 181);
    put(swb_pkg::ADDR_CTRL, 8'h01);
    get(swb_pkg::ADDR_CTRL);
    chk("reset start", 8'h21, got & 8'hFD);
    idle();
    pres = here;
    get(swb_pkg::ADDR_CTRL);
    chk("presence", ctrl_exp(8'h00, pres, rres), got);
    $display("test reset done");
  endtask : do_reset
  task automatic slot(input logic one, input logic b);
    logic [7:0] s;
    s = one ? 8'h08 : 8'h04;
    ret_bit = b;
    put(swb_pkg::ADDR_CTRL, s);
    get(swb_pkg::ADDR_CTRL);
    chk("slot start", ctrl_exp(s, pres, rres), got);
    idle();
    if (one) rres = b;
    get(swb_pkg::ADDR_CTRL);
    chk("slot end", ctrl_exp(8'h00, pres, rres), got);
    $display("test slot done");
  endtask : slot
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // ----
  // Main sequence
  // ----
  initial
  begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    present = 1'b0;
    ret_bit = 1'b1;
    wait_us = 8'h1E;
    pulse_us = 8'h64;
    bad_count = 0;
    n_compared = 0;
    pres = 1'b0;
    rres = 1'b0;
    void'($urandom(32'h2C5E));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++)
    begin
      get(a[1:0]);
      chk("reset value", a == 1 ? 8'h0A : 8'h00, got);
    end
    put(2'h2, 8'($urandom));
    get(swb_pkg::ADDR_CTRL);
    chk("unmapped write", 8'h00, got);
    do_reset(1'b1);
    slot(1'b1, 1'b0);
    slot(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) slot(1'($urandom), 1'($urandom));
    do_reset(1'b0);
    do_reset(1'b1);
    results();
  end
  // Bound of about 60000 cycles, well above the planned sequences
  initial
  begin
    #6000000;
    bad_count++;
    results();
  end
endmodule : testbench
